// >>> verilog/mmd_map.sv
`timescale 1ns/1ns
// What this block does
// - After reset the 128-byte register window decodes at address zero.
// - Writing the placement register moves the window to any 4 Kbyte page.
// - Mapping registers set RAM and EEPROM bases; the configuration register enables EEPROM and ROM.
// - In test mode, setting the program memory enable bit maps ROM.
// - Ranges cover 768 RAM, 640 EEPROM, 24K ROM bytes; disabled arrays omitted.
// - Registers sit at fixed offsets from the current window base.
// - Mode pins are caught on the third edge after reset release and shown in status bits.
module mmd_map #(
    parameter logic RAM_PRESENT = 1'b1,
    parameter logic EE_PRESENT = 1'b1,
    parameter logic ROM_PRESENT = 1'b1
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [15:0] bus_addr,
    input wire logic bus_write,
    input wire logic bus_valid,
    input wire logic [7:0] bus_wdata,
    output logic [7:0] bus_rdata,
    output logic bus_reg_hit,
    output logic ram_select,
    output logic ee_select,
    output logic rom_select,
    output logic [15:0] array_addr,
    input wire logic mode_select_pin_a,
    input wire logic mode_select_pin_b,
    output logic special_mode,
    output logic [7:0] port_a_out,
    output logic [7:0] port_a_oe,
    output logic [7:0] port_b_out,
    output logic [7:0] port_b_oe,
    output logic [7:0] port_c_out,
    output logic [7:0] port_c_oe,
    output logic [7:0] port_d_out,
    output logic [7:0] port_d_oe,
    output logic [7:0] port_f_out,
    output logic [7:0] port_f_oe
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [1:0] mode_select_pin_a_sync;
        logic [1:0] mode_select_pin_b_sync;
        logic [1:0] settle_cnt;
        logic smod;
        logic mda;
        logic [7:0] ram_place;
        logic [7:0] ee_place;
        logic [7:0] config_bits;
        logic [9:0][7:0] regs;
    } mmd_state_t;

    mmd_state_t cur_q;
    mmd_state_t nxt_d;
    mmd_pkg::mmd_sel_t sel;
    logic [6:0] reg_offset;
    logic program_memory_enable;
    logic ee_enable;
    logic reg_wr;

    // ROM only visible once enabled; in test mode that is software's call
    assign program_memory_enable = ROM_PRESENT
        && nxt_dummy_rom(cur_q.config_bits, cur_q.smod, cur_q.mda);
    assign ee_enable = EE_PRESENT && cur_q.config_bits[mmd_pkg::MMD_CFG_EE_EN_BIT];

    function automatic logic nxt_dummy_rom(input logic [7:0] cfg, input logic smod,
                                           input logic mda);
        nxt_dummy_rom = cfg[mmd_pkg::MMD_CFG_ROM_EN_BIT] || (!smod && !mda);
    endfunction : nxt_dummy_rom

    mmd_decode u_decode (
        .addr(bus_addr),
        .reg_page(cur_q.ram_place[3:0]),
        .ram_page(cur_q.ram_place[7:4]),
        .ee_page(cur_q.ee_place[7:4]),
        .rom_en(program_memory_enable),
        .ee_en(ee_enable),
        .sel(sel),
        .reg_offset(reg_offset)
    );

    // ****************************************************************
    // Select outputs
    // ****************************************************************
    assign bus_reg_hit = bus_valid && (sel == mmd_pkg::MMD_SEL_REG);
    assign ram_select = bus_valid && RAM_PRESENT && (sel == mmd_pkg::MMD_SEL_RAM);
    assign ee_select = bus_valid && (sel == mmd_pkg::MMD_SEL_EE);
    assign rom_select = bus_valid && (sel == mmd_pkg::MMD_SEL_ROM);
    assign array_addr = bus_addr;
    assign reg_wr = bus_reg_hit && bus_write;
    assign special_mode = cur_q.smod;

    // Port drivers straight from the register copies
    assign port_a_out = cur_q.regs[0];
    assign port_a_oe = cur_q.regs[1];
    assign port_b_oe = cur_q.regs[2];
    assign port_f_oe = cur_q.regs[3];
    assign port_b_out = cur_q.regs[4];
    assign port_f_out = cur_q.regs[5];
    assign port_c_out = cur_q.regs[6];
    assign port_c_oe = cur_q.regs[7];
    assign port_d_out = cur_q.regs[8];
    assign port_d_oe = cur_q.regs[9];

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        nxt_d = cur_q;
        nxt_d.mode_select_pin_a_sync = {cur_q.mode_select_pin_a_sync[0], mode_select_pin_a};
        nxt_d.mode_select_pin_b_sync = {cur_q.mode_select_pin_b_sync[0], mode_select_pin_b};
        // Pins are read once both sync flops hold real samples; earlier the
        // second flop still shows its reset value, not the pin
        if (cur_q.settle_cnt != mmd_pkg::MMD_MODE_DONE_CNT) begin
            nxt_d.settle_cnt = cur_q.settle_cnt + 2'h1;
        end
        if (cur_q.settle_cnt == mmd_pkg::MMD_MODE_CAPTURE_CNT) begin
            nxt_d.smod = !cur_q.mode_select_pin_b_sync[1];
            nxt_d.mda = cur_q.mode_select_pin_a_sync[1];
        end
        if (reg_wr) begin
            if (reg_offset < mmd_pkg::MMD_REG_COUNT) begin
                nxt_d.regs[reg_offset[3:0]] = bus_wdata;
                if (reg_offset == mmd_pkg::MMD_OFS_PORT_D_DATA
                    || reg_offset == mmd_pkg::MMD_OFS_PORT_D_DIR) begin
                    nxt_d.regs[reg_offset[3:0]] = bus_wdata & mmd_pkg::MMD_PORT_D_MASK;
                end
            end else if (reg_offset == mmd_pkg::MMD_OFS_RAM_PLACE) begin
                nxt_d.ram_place = bus_wdata;
            end else if (reg_offset == mmd_pkg::MMD_OFS_EE_PLACE) begin
                nxt_d.ee_place = bus_wdata;
            end else if (reg_offset == mmd_pkg::MMD_OFS_CONFIG) begin
                nxt_d.config_bits = bus_wdata;
            end
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        bus_rdata = 8'h00;
        if (bus_reg_hit) begin
            if (reg_offset < mmd_pkg::MMD_REG_COUNT) begin
                bus_rdata = cur_q.regs[reg_offset[3:0]];
            end else if (reg_offset == mmd_pkg::MMD_OFS_RAM_PLACE) begin
                bus_rdata = cur_q.ram_place;
            end else if (reg_offset == mmd_pkg::MMD_OFS_EE_PLACE) begin
                bus_rdata = cur_q.ee_place;
            end else if (reg_offset == mmd_pkg::MMD_OFS_CONFIG) begin
                bus_rdata = cur_q.config_bits;
            end else if (reg_offset == mmd_pkg::MMD_OFS_MODE_STATUS) begin
                bus_rdata[mmd_pkg::MMD_MODE_SMOD_BIT] = cur_q.smod;
                bus_rdata[mmd_pkg::MMD_MODE_MDA_BIT] = cur_q.mda;
            end
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cur_q <= '0;
            cur_q.ram_place <= mmd_pkg::MMD_RAM_PLACE_RST;
            cur_q.ee_place <= mmd_pkg::MMD_EE_PLACE_RST;
            cur_q.config_bits <= mmd_pkg::MMD_CONFIG_RST;
        end else begin
            cur_q <= nxt_d;
        end
    end

endmodule : mmd_map

// >>> verilog/mmd_pkg.sv
package mmd_pkg;

    // ****************************************************************
    // Address space and array sizes
    // ****************************************************************
    localparam logic [15:0] MMD_REG_BLOCK_SIZE = 16'h0080;
    localparam logic [15:0] MMD_RAM_SIZE = 16'h0300;
    localparam logic [15:0] MMD_EE_SIZE = 16'h0280;
    localparam logic [15:0] MMD_ROM_SIZE = 16'h6000;

    // ****************************************************************
    // Register offsets inside the window
    // ****************************************************************
    localparam logic [6:0] MMD_OFS_PORT_A_DATA = 7'h00;
    localparam logic [6:0] MMD_OFS_PORT_A_DIR = 7'h01;
    localparam logic [6:0] MMD_OFS_PORT_B_DIR = 7'h02;
    localparam logic [6:0] MMD_OFS_PORT_F_DIR = 7'h03;
    localparam logic [6:0] MMD_OFS_PORT_B_DATA = 7'h04;
    localparam logic [6:0] MMD_OFS_PORT_F_DATA = 7'h05;
    localparam logic [6:0] MMD_OFS_PORT_C_DATA = 7'h06;
    localparam logic [6:0] MMD_OFS_PORT_C_DIR = 7'h07;
    localparam logic [6:0] MMD_OFS_PORT_D_DATA = 7'h08;
    localparam logic [6:0] MMD_OFS_PORT_D_DIR = 7'h09;
    localparam logic [6:0] MMD_OFS_RAM_PLACE = 7'h3D;
    localparam logic [6:0] MMD_OFS_MODE_STATUS = 7'h3C;
    localparam logic [6:0] MMD_OFS_CONFIG = 7'h3F;
    localparam logic [6:0] MMD_OFS_EE_PLACE = 7'h37;
    localparam logic [6:0] MMD_REG_COUNT = 7'h0A;
    localparam logic [7:0] MMD_PORT_D_MASK = 8'h3F;

    // ****************************************************************
    // Reset values and field positions
    // ****************************************************************
    // Register block at page 0, RAM at page 0 (register wins overlap)
    localparam logic [7:0] MMD_RAM_PLACE_RST = 8'h00;
    // EEPROM page upper nibble, 4 Kbyte units
    localparam logic [7:0] MMD_EE_PLACE_RST = 8'h00;
    localparam logic [7:0] MMD_CONFIG_RST = 8'h00;
    localparam int MMD_CFG_ROM_EN_BIT = 2;
    localparam int MMD_CFG_EE_EN_BIT = 0;
    localparam logic [15:0] MMD_ROM_BASE = 16'hA000;
    localparam int MMD_MODE_SMOD_BIT = 6;
    localparam int MMD_MODE_MDA_BIT = 5;
    // Mode pins are taken on the third edge after reset release
    localparam logic [1:0] MMD_MODE_CAPTURE_CNT = 2'h2;
    localparam logic [1:0] MMD_MODE_DONE_CNT = 2'h3;

    // Result of one decode
    typedef enum logic [4:0] {
        MMD_SEL_NONE = 5'b00001,
        MMD_SEL_REG = 5'b00010,
        MMD_SEL_RAM = 5'b00100,
        MMD_SEL_EE = 5'b01000,
        MMD_SEL_ROM = 5'b10000
    } mmd_sel_t;

endpackage : mmd_pkg

// >>> verilog/mmd_decode.sv
`timescale 1ns/1ns
module mmd_decode (
    addr,
    reg_page,
    ram_page,
    ee_page,
    rom_en,
    ee_en,
    sel,
    reg_offset
);
    input wire logic [15:0] addr;
    input wire logic [3:0] reg_page;
    input wire logic [3:0] ram_page;
    input wire logic [3:0] ee_page;
    input wire logic rom_en;
    input wire logic ee_en;
    output mmd_pkg::mmd_sel_t sel;
    output logic [6:0] reg_offset;

    // ****************************************************************
    // Range test
    // ****************************************************************
    function automatic logic mmd_in_range(input logic [15:0] a, input logic [15:0] base,
                                          input logic [15:0] size);
        logic [15:0] diff;
        diff = a - base;
        mmd_in_range = (diff < size);
    endfunction : mmd_in_range

    // Register window first, so it hides any array it overlaps
    always_comb begin
        reg_offset = addr[6:0];
        if (mmd_in_range(addr, {reg_page, 12'h000}, mmd_pkg::MMD_REG_BLOCK_SIZE)) begin
            sel = mmd_pkg::MMD_SEL_REG;
        end else if (mmd_in_range(addr, {ram_page, 12'h000}, mmd_pkg::MMD_RAM_SIZE)) begin
            sel = mmd_pkg::MMD_SEL_RAM;
        end else if (ee_en && mmd_in_range(addr, {ee_page, 12'h000},
                                           mmd_pkg::MMD_EE_SIZE)) begin
            sel = mmd_pkg::MMD_SEL_EE;
        end else if (rom_en && mmd_in_range(addr, mmd_pkg::MMD_ROM_BASE,
                                            mmd_pkg::MMD_ROM_SIZE)) begin
            sel = mmd_pkg::MMD_SEL_ROM;
        end else begin
            sel = mmd_pkg::MMD_SEL_NONE;
        end
    end

endmodule : mmd_decode

// >>> test/mmd_cpu_model.sv
`timescale 1ns/1ns
// ****************************************************************
// Processor bus master model
// ****************************************************************
module mmd_cpu_model (
    input wire logic sys_clk,
    input wire logic [7:0] bus_rdata,
    output logic [15:0] bus_addr,
    output logic bus_write,
    output logic bus_valid,
    output logic [7:0] bus_wdata
);
    // Idle bus: write data flips so a stale byte is never mistaken for data
    task automatic idle();
        @(negedge sys_clk);
        bus_valid = 1'b0;
        bus_write = 1'b0;
        bus_wdata = ~bus_wdata;
    endtask : idle
    // One byte per cycle; gap idles first to play a slow master
    task automatic access(input logic w, input logic [15:0] a, input logic [7:0] d,
            input int gap, output logic [7:0] q);
        repeat (gap) idle();
        @(negedge sys_clk);
        bus_valid = 1'b1;
        bus_write = w;
        bus_addr = a;
        bus_wdata = d;
        @(posedge sys_clk);
        q = bus_rdata;
    endtask : access
    // Quiet bus until the first access
    initial begin
        bus_addr = 16'h0000;
        bus_write = 1'b0;
        bus_valid = 1'b0;
        bus_wdata = 8'h00;
    end
endmodule : mmd_cpu_model

// >>> test/mmd_map_sva.sv
`timescale 1ns/1ns
// ****************************************************************
// Decode checker
// ****************************************************************
module mmd_map_sva (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [15:0] bus_addr,
    input wire logic bus_write,
    input wire logic bus_valid,
    input wire logic [7:0] bus_wdata,
    input wire logic [7:0] bus_rdata,
    input wire logic bus_reg_hit,
    input wire logic ram_select,
    input wire logic ee_select,
    input wire logic rom_select,
    input wire logic [15:0] array_addr,
    input wire logic mode_select_pin_b,
    input wire logic special_mode,
    input wire logic [7:0] port_a_out
);
    logic [3:0] reg_pg_q, ram_pg_q, ee_pg_q;
    logic [1:0] cfg_q;
    logic [2:0] cyc_q;
    logic wr;
    assign wr = bus_valid && bus_write && bus_reg_hit;
    // Shadow of the placement and enable state, plus edges since reset
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            {reg_pg_q, ram_pg_q, ee_pg_q, cfg_q, cyc_q} <= '0;
        end else begin
            if (wr && bus_addr[6:0] == 7'h3D) {ram_pg_q, reg_pg_q} <= bus_wdata;
            if (wr && bus_addr[6:0] == 7'h37) ee_pg_q <= bus_wdata[7:4];
            if (wr && bus_addr[6:0] == 7'h3F) cfg_q <= {bus_wdata[2], bus_wdata[0]};
            if (cyc_q != 3'h7) cyc_q <= cyc_q + 3'h1;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    property p_win; bus_valid |-> bus_reg_hit == (bus_addr[15:7] == {reg_pg_q, 5'h00}); endproperty
    property p_prio; bus_reg_hit |-> !(ram_select || ee_select || rom_select); endproperty
    property p_one; $onehot0({ram_select, ee_select, rom_select}); endproperty
    property p_ram; ram_select |-> (bus_addr - {ram_pg_q, 12'h000}) < 16'h0300; endproperty
    property p_ee; ee_select |-> cfg_q[0] && (bus_addr - {ee_pg_q, 12'h000}) < 16'h0280; endproperty
    property p_rom; rom_select |-> bus_addr >= 16'hA000; endproperty
    property p_program_memory_enable; bus_valid && cfg_q[1] && !bus_reg_hit && bus_addr >= 16'hA000 |-> rom_select;
    endproperty
    property p_rd0; !bus_reg_hit |-> bus_rdata == 8'h00; endproperty
    property p_port; wr && bus_addr[6:0] == 7'h00 |=> port_a_out == $past(bus_wdata); endproperty
    property p_mode; cyc_q == 3'h5 |-> special_mode == !mode_select_pin_b; endproperty
    property p_addr; array_addr == bus_addr; endproperty
    a_win: assert property (p_win) else $error("window hit wrong");
    a_prio: assert property (p_prio) else $error("array chosen inside window");
    a_one: assert property (p_one) else $error("two arrays chosen");
    a_ram: assert property (p_ram) else $error("ram outside range");
    a_ee: assert property (p_ee) else $error("eeprom outside range");
    a_rom: assert property (p_rom) else $error("rom outside range");
    a_program_memory_enable: assert property (p_program_memory_enable) else $error("rom not shown");
    a_rd0: assert property (p_rd0) else $error("read data outside window");
    a_port: assert property (p_port) else $error("port write lost");
    a_mode: assert property (p_mode) else $error("mode status wrong");
    a_addr: assert property (p_addr) else $error("array address wrong");
    c_move: cover property (wr && bus_addr[6:0] == 7'h3D);
    c_ee: cover property (ee_select);
    c_rom: cover property (rom_select);
endmodule : mmd_map_sva
bind mmd_map mmd_map_sva i_sva (.sys_clk(sys_clk), .reset_n(reset_n), .bus_addr(bus_addr),
    .bus_write(bus_write), .bus_valid(bus_valid), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .bus_reg_hit(bus_reg_hit), .ram_select(ram_select), .ee_select(ee_select),
    .rom_select(rom_select), .array_addr(array_addr), .mode_select_pin_b(mode_select_pin_b),
    .special_mode(special_mode), .port_a_out(port_a_out));

// >>> test/mmd_map_tb.sv
`timescale 1ns/1ns
// ****************************************************************
// Random decode bench
// ****************************************************************
module mmd_map_tb;
    logic sys_clk, reset_n, bus_write, bus_valid, hit, ram_sel, ee_sel, rom_sel, smode;
    logic pin_a, pin_b;
    logic [7:0] mode_rd;
    logic [9:0][7:0] po;
    logic [15:0] bus_addr, base;
    logic [7:0] bus_wdata, bus_rdata, v, q;
    logic [3:0] reg_pg, ram_pg, ee_pg;
    logic [1:0] cfg;
    logic [7:0] port_q [10];
    logic [15:0] c [16];
    integer seed, failures, checks, t, i, p;
    mmd_map i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .bus_addr(bus_addr),
        .bus_write(bus_write), .bus_valid(bus_valid), .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata), .bus_reg_hit(hit), .ram_select(ram_sel), .ee_select(ee_sel),
        .rom_select(rom_sel), .array_addr(), .mode_select_pin_a(pin_a),
        .mode_select_pin_b(pin_b), .special_mode(smode), .port_a_out(po[0]),
        .port_a_oe(po[1]), .port_b_out(po[4]), .port_b_oe(po[2]), .port_c_out(po[6]),
        .port_c_oe(po[7]), .port_d_out(po[8]), .port_d_oe(po[9]), .port_f_out(po[5]),
        .port_f_oe(po[3]));
    mmd_cpu_model i_cpu (.sys_clk(sys_clk), .bus_rdata(bus_rdata), .bus_addr(bus_addr),
        .bus_write(bus_write), .bus_valid(bus_valid), .bus_wdata(bus_wdata));
    // Expected {window, ram, eeprom, rom}; window wins any overlap
    function automatic logic [3:0] exp_dec(input logic [15:0] x);
        logic r;
        r = (x[15:7] == {reg_pg, 5'h00});
        return {r, !r && (x - {ram_pg, 12'h000}) < 16'h0300,
            !r && cfg[0] && (x - {ee_pg, 12'h000}) < 16'h0280,
            !r && (cfg[1] || mode_rd[6:5] == 2'b00) && x >= 16'hA000};
    endfunction : exp_dec
    // Expected read data at a window offset
    function automatic logic [7:0] exp_rd(input logic [6:0] o);
        if (o < 7'h0A) return port_q[o[3:0]];
        if (o == 7'h3D) return {ram_pg, reg_pg};
        if (o == 7'h37) return {ee_pg, 4'h0};
        if (o == 7'h3F) return {5'h00, cfg[1], 1'b0, cfg[0]};
        if (o == 7'h3C) return mode_rd;
        return 8'h00;
    endfunction : exp_rd
    task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : cmp
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        i_cpu.access(1'b1, a, d, $random(seed) & 1, q);
        if (a[15:7] == {reg_pg, 5'h00} && a[6:0] < 7'h0A)
            port_q[a[3:0]] = (a[3:1] == 3'h4) ? d & 8'h3F : d;
    endtask : wr
    // Reads never change state, so selects and data still stand at the edge
    task automatic chk(input logic [15:0] x);
        logic [7:0] g;
        logic [3:0] e;
        e = exp_dec(x);
        i_cpu.access(1'b0, x, 8'h00, $random(seed) & 1, g);
        cmp("decode", {4'h0, e}, {4'h0, hit, ram_sel, ee_sel, rom_sel});
        cmp("read data", e[3] ? exp_rd(x[6:0]) : 8'h00, g);
        if (e[3] && x[6:0] < 7'h0A) cmp("port pin", port_q[x[3:0]], po[x[3:0]]);
    endtask : chk
    task automatic end_of_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_of_test
    // 100 ns clock
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    // Hang guard
    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        end_of_test();
    end
    // Pass 0 resets into special test mode, pass 1 into single chip mode,
    // where ROM shows with no config write; random placements with corners
    initial begin
        reset_n = 1'b0;
        seed = 25987;
        failures = 0;
        checks = 0;
        for (p = 0; p < 2; p++) begin
        i_cpu.idle();
        {reset_n, reg_pg, ram_pg, ee_pg, cfg} = '0;
        pin_a = (p == 0);
        pin_b = (p != 0);
        mode_rd = (p == 0) ? 8'h60 : 8'h00;
        for (i = 0; i < 10; i++) port_q[i] = 8'h00;
        repeat (12) @(negedge sys_clk);
        reset_n = 1'b1;
        repeat (5) @(negedge sys_clk);
        cmp("special mode", {7'h00, mode_rd[6]}, {7'h00, smode});
        for (t = 0; t < 5; t++) begin
            base = {reg_pg, 12'h000};
            if (t > 0) begin
                v = 8'($random(seed));
                wr(base | 16'h003D, {2'b00, v[5:0]});
                {ram_pg, reg_pg} = {2'b00, v[5:0]};
                base = {reg_pg, 12'h000};
                v = 8'($random(seed));
                ee_pg = 4'h4 + {2'b00, v[1:0]};
                cfg = v[3:2];
                wr(base | 16'h0037, {ee_pg, 4'h0});
                wr(base | 16'h003F, {5'h00, cfg[1], 1'b0, cfg[0]});
            end
            for (i = 0; i < 10; i++) wr(base + 16'(i), 8'($random(seed)));
            wr(base | 16'h0020, 8'h5A);
            c = '{base, base | 16'h007F, base + 16'h0080, base | 16'h0020, {ram_pg, 12'h2FF},
                {ram_pg, 12'h300}, {ee_pg, 12'h27F}, {ee_pg, 12'h280}, 16'hA000, 16'h9FFF,
                16'hFFFF, 16'h0000, base | 16'h003C, base | 16'h003D, base | 16'h0037,
                base | 16'h003F};
            for (i = 0; i < 16; i++) chk(c[i]);
            for (i = 0; i < 10; i++) chk(base + 16'(i));
            for (i = 0; i < 20; i++) chk(16'($random(seed)));
            $display("test %0d done", t);
        end
        end
        end_of_test();
    end
endmodule : mmd_map_tb
